// file: hdl/afpv_consts.vh
// Register offsets, field positions, reset values and masks of the alert and power-good bank
`ifndef AFPV_CONSTS_VH
`define AFPV_CONSTS_VH

// Register pointer values
`define AFPV_OFS_ALERT_MASK_ENABLE  8'h0f
`define AFPV_OFS_PG_UPPER_LIMIT     8'h10
`define AFPV_OFS_PG_LOWER_LIMIT     8'h11
`define AFPV_OFS_MAKER_IDENTITY     8'hfe
`define AFPV_OFS_DIE_IDENTITY       8'hff

// Alert mask/enable field positions
`define AFPV_SUM_SEL_HI             14
`define AFPV_SUM_SEL_LO             12
`define AFPV_WARN_LATCH_BIT         11
`define AFPV_CRIT_LATCH_BIT         10
`define AFPV_CRIT_FLAGS_HI          9
`define AFPV_CRIT_FLAGS_LO          7
`define AFPV_SUM_FLAG_BIT           6
`define AFPV_WARN_FLAGS_HI          5
`define AFPV_WARN_FLAGS_LO          3
`define AFPV_PG_FLAG_BIT            2
`define AFPV_TC_FLAG_BIT            1
`define AFPV_CONV_FLAG_BIT          0

// Reset values
`define AFPV_RST_ALERT_MASK_ENABLE  16'h0002
`define AFPV_RST_PG_UPPER_LIMIT     16'h2710
`define AFPV_RST_PG_LOWER_LIMIT     16'h2328

// Writable bits of the limit registers (sign and data, bits 2..0 reserved)
`define AFPV_LIMIT_MASK             16'hfff8

// Arbitrary identity values, not tied to any real part
`define AFPV_MAKER_CODE             16'h4d4b
`define AFPV_DIE_CODE               16'h0101

// Serial address of the device (arbitrary default)
`define AFPV_DEV_ADDR               7'h40

`endif

// file: hdl/afpv_serial_slave.v
// Two-wire serial slave with register pointer and 16-bit word transfers
`timescale 1ns/100ps
`default_nettype none

module afpv_serial_slave
(
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        scl_pin,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg  [7:0]  reg_ptr,
  output reg         wr_stb,
  output reg  [15:0] wr_data,
  output wire        rd_take,
  input  wire [15:0] rd_data
);

  `include "afpv_consts.vh"

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_PTR  = 3'h2;
  localparam [2:0] S_DATA = 3'h3;
  localparam [2:0] S_READ = 3'h4;

  reg        scl_s1;
  reg        scl_s2;
  reg        scl_d;
  reg        sda_s1;
  reg        sda_s2;
  reg        sda_d;
  reg [2:0]  state;
  reg [3:0]  bit_cnt;
  reg [7:0]  shreg;
  reg [7:0]  data_hi;
  reg        byte_lsb;
  reg        ack_phase;
  reg        mst_nack;
  reg [15:0] tx;

  wire scl_rise   = scl_s2 & ~scl_d;
  wire scl_fall   = ~scl_s2 & scl_d;
  wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire byte_end   = scl_fall & ~ack_phase & (bit_cnt == 4'h8);
  wire addr_hit   = (shreg[7:1] == `AFPV_DEV_ADDR);

  // Word is captured for sending on the same edge the read side effect fires
  assign rd_take = byte_end & (state == S_ADDR) & addr_hit & shreg[0];

  // Pin synchronisers; only the second stage and its delayed copy are looked at
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_pin;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // Bit and byte sequencer; data changes only while the clock line is low
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state     <= S_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      data_hi   <= 8'h00;
      byte_lsb  <= 1'b0;
      ack_phase <= 1'b0;
      mst_nack  <= 1'b0;
      tx        <= 16'h0000;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      reg_ptr   <= 8'h00;
      wr_stb    <= 1'b0;
      wr_data   <= 16'h0000;
    end
    else
    begin
      sda_out <= 1'b0;
      wr_stb  <= 1'b0;
      if (start_cond)
      begin
        state     <= S_ADDR;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        byte_lsb  <= 1'b0;
        sda_oe    <= 1'b0;
      end
      else if (stop_cond)
      begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end
      else if (state != S_IDLE)
      begin
        if (scl_rise && !ack_phase && state != S_READ)
        begin
          shreg   <= {shreg[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (scl_rise && state == S_READ)
        begin
          // Master acknowledge sampled after each sent byte
          if (ack_phase)
            mst_nack <= sda_s2;
          else
            bit_cnt <= bit_cnt + 4'h1;
        end
        if (byte_end)
        begin
          bit_cnt <= 4'h0;
          case (state)
            S_ADDR:
            begin
              if (addr_hit)
              begin
                sda_oe    <= 1'b1;
                ack_phase <= 1'b1;
                mst_nack  <= 1'b0;
                state     <= shreg[0] ? S_READ : S_PTR;
                if (shreg[0])
                  tx <= rd_data;
              end
              else
                state <= S_IDLE;
            end
            S_PTR:
            begin
              reg_ptr   <= shreg;
              sda_oe    <= 1'b1;
              ack_phase <= 1'b1;
              state     <= S_DATA;
            end
            S_DATA:
            begin
              sda_oe    <= 1'b1;
              ack_phase <= 1'b1;
              byte_lsb  <= ~byte_lsb;
              if (byte_lsb)
              begin
                wr_stb  <= 1'b1;
                wr_data <= {data_hi, shreg};
              end
              else
                data_hi <= shreg;
            end
            S_READ:
            begin
              // Release the line for the master acknowledge
              sda_oe    <= 1'b0;
              ack_phase <= 1'b1;
            end
            default:
              state <= S_IDLE;
          endcase
        end
        else if (scl_fall && ack_phase)
        begin
          ack_phase <= 1'b0;
          sda_oe    <= 1'b0;
          if (state == S_READ && !mst_nack)
          begin
            // Rotate so a long read repeats the word without a second fetch
            sda_oe <= ~tx[15];
            tx     <= {tx[14:0], tx[15]};
          end
          else if (state == S_READ)
            state <= S_IDLE;
        end
        else if (scl_fall && state == S_READ && bit_cnt != 4'h0)
        begin
          sda_oe <= ~tx[15];
          tx     <= {tx[14:0], tx[15]};
        end
      end
    end
  end

endmodule // afpv_serial_slave

`default_nettype wire

// file: hdl/afpv_alert_bank.v
// Alert mask/enable, power-good limits and identity registers with alert pin logic
//
// Notes on behaviour
// - Reading the mask/enable register clears critical, sum, warning and conversion flags.
// - Writing the mask/enable register changes control fields only, never flags.
// - Bits 14..12 pick channels for the shunt sum; channel enables unaffected.
// - Bit 11 set makes the warning pin latch; clear keeps it transparent.
// - Bit 10 set makes the critical pin latch; clear keeps it transparent.
// - Bits 9..7 set on per-channel critical over-limit, assert critical pin, clear on read.
// - Bit 6 sets on sum over-limit, asserts critical pin, clears on read.
// - Bits 5..3 set on averaged warning over-limit, assert warning pin, clear on read.
// - Bit 2 mirrors the power-good pin and is not cleared by a read.
// - Bit 1 mirrors timing-control pin, resets high, restored only by reset.
// - Bit 0 sets on conversions done; clears on config write or mask read.
// - Power-good pin rises once every bus channel is above the upper limit.
// - While power-good, any bus channel below the lower limit drops the pin.
// - Limit registers: sign bit 15, data bits 14..3 at 8 mV, 2..0 reserved.
// - Reset loads upper limit with 10 V code, lower with 9 V code.
// - Two read-only identity words sit at the last two pointer values.
// - Critical compares each conversion, warning compares averaged value.
// - Shunt sum refreshes per cycle of selected channels, 40 uV step.
`timescale 1ns/100ps
`default_nettype none

module afpv_alert_bank
(
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        scl_pin,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        soft_reset,
  input  wire        cfg_write_clear,
  input  wire        conv_done,
  input  wire [2:0]  crit_over,
  input  wire        sum_over,
  input  wire [2:0]  warn_over,
  input  wire        bus_meas_en,
  input  wire        bus_valid,
  input  wire [1:0]  bus_ch,
  input  wire [15:0] bus_volt,
  input  wire        timing_ctrl_event,
  output reg  [2:0]  sum_channel_select,
  output reg         critical_alert_n,
  output reg         warning_alert_n,
  output reg         power_good_pin,
  output reg         timing_ctrl_pin
);

  `include "afpv_consts.vh"

  reg        warn_pin_latch_on;
  reg        crit_pin_latch_on;
  reg [2:0]  crit_channel_flags;
  reg        sum_over_flag;
  reg [2:0]  warn_channel_flags;
  reg        conversion_done_flag;
  reg        crit_hold;
  reg        warn_hold;
  reg [15:0] power_good_upper_limit;
  reg [15:0] power_good_lower_limit;
  reg [2:0]  above_upper;
  reg [2:0]  below_lower;

  wire [7:0]  reg_ptr;
  wire        wr_stb;
  wire [15:0] wr_data;
  wire        rd_take;
  wire [15:0] rd_data;

  // Soft reset puts the bank registers back to their power-on state; the serial front end resets only on nrst
  wire rst_all = ~nrst | soft_reset;
  wire mask_rd = rd_take & (reg_ptr == `AFPV_OFS_ALERT_MASK_ENABLE);
  wire mask_wr = wr_stb & (reg_ptr == `AFPV_OFS_ALERT_MASK_ENABLE);
  wire upper_wr = wr_stb & (reg_ptr == `AFPV_OFS_PG_UPPER_LIMIT);
  wire lower_wr = wr_stb & (reg_ptr == `AFPV_OFS_PG_LOWER_LIMIT);

  // Signed compare of two limit-format words, reserved low bits ignored
  function signed_gt;
    input [15:0] a;
    input [15:0] b;
    begin
      signed_gt = $signed(a & `AFPV_LIMIT_MASK) > $signed(b & `AFPV_LIMIT_MASK);
    end
  endfunction

  // Read mux; unmapped pointers read zero, flags seen before any clear
  function [15:0] read_word;
    input [7:0] ptr;
    begin
      case (ptr)
        `AFPV_OFS_ALERT_MASK_ENABLE:
          read_word = {1'b0, sum_channel_select, warn_pin_latch_on, crit_pin_latch_on,
                       crit_channel_flags, sum_over_flag, warn_channel_flags,
                       power_good_pin, timing_ctrl_pin, conversion_done_flag};
        `AFPV_OFS_PG_UPPER_LIMIT:
          read_word = power_good_upper_limit;
        `AFPV_OFS_PG_LOWER_LIMIT:
          read_word = power_good_lower_limit;
        `AFPV_OFS_MAKER_IDENTITY:
          read_word = `AFPV_MAKER_CODE;
        `AFPV_OFS_DIE_IDENTITY:
          read_word = `AFPV_DIE_CODE;
        default:
          read_word = 16'h0000;
      endcase
    end
  endfunction

  assign rd_data = read_word(reg_ptr);

  // Serial front end
  afpv_serial_slave u_serial
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .scl_pin  (scl_pin),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .reg_ptr  (reg_ptr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_take  (rd_take),
    .rd_data  (rd_data)
  );

  // Control fields of the mask/enable register; flags are not touched here
  always @(posedge core_clk)
  begin
    if (rst_all)
    begin
      sum_channel_select <= 3'h0;
      warn_pin_latch_on  <= 1'b0;
      crit_pin_latch_on  <= 1'b0;
    end
    else if (mask_wr)
    begin
      sum_channel_select <= wr_data[`AFPV_SUM_SEL_HI:`AFPV_SUM_SEL_LO];
      warn_pin_latch_on  <= wr_data[`AFPV_WARN_LATCH_BIT];
      crit_pin_latch_on  <= wr_data[`AFPV_CRIT_LATCH_BIT];
    end
  end

  // Sticky flags; a new event in the read cycle survives the clear
  always @(posedge core_clk)
  begin
    if (rst_all)
    begin
      crit_channel_flags   <= 3'h0;
      sum_over_flag        <= 1'b0;
      warn_channel_flags   <= 3'h0;
      conversion_done_flag <= 1'b0;
    end
    else
    begin
      crit_channel_flags   <= (crit_channel_flags & ~{3{mask_rd}}) | crit_over;
      sum_over_flag        <= (sum_over_flag & ~mask_rd) | sum_over;
      warn_channel_flags   <= (warn_channel_flags & ~{3{mask_rd}}) | warn_over;
      conversion_done_flag <= (conversion_done_flag & ~mask_rd & ~cfg_write_clear)
                              | conv_done;
    end
  end

  // Alert pins: transparent follows the condition, latch mode holds to a read
  wire crit_cond      = (|crit_over) | sum_over;
  wire warn_cond      = |warn_over;
  wire next_crit_hold = crit_pin_latch_on & ((crit_hold & ~mask_rd) | crit_cond);
  wire next_warn_hold = warn_pin_latch_on & ((warn_hold & ~mask_rd) | warn_cond);

  always @(posedge core_clk)
  begin
    if (rst_all)
    begin
      crit_hold        <= 1'b0;
      warn_hold        <= 1'b0;
      critical_alert_n <= 1'b1;
      warning_alert_n  <= 1'b1;
    end
    else
    begin
      crit_hold        <= next_crit_hold;
      warn_hold        <= next_warn_hold;
      critical_alert_n <= ~(crit_cond | next_crit_hold);
      warning_alert_n  <= ~(warn_cond | next_warn_hold);
    end
  end

  // Power-good limits; reserved bits masked on write
  always @(posedge core_clk)
  begin
    if (rst_all)
    begin
      power_good_upper_limit <= `AFPV_RST_PG_UPPER_LIMIT;
      power_good_lower_limit <= `AFPV_RST_PG_LOWER_LIMIT;
    end
    else
    begin
      if (upper_wr)
        power_good_upper_limit <= wr_data & `AFPV_LIMIT_MASK;
      if (lower_wr)
        power_good_lower_limit <= wr_data & `AFPV_LIMIT_MASK;
    end
  end

  // Per-channel compare of each bus reading; nothing moves unless measuring
  always @(posedge core_clk)
  begin
    if (rst_all)
    begin
      above_upper <= 3'h0;
      below_lower <= 3'h0;
    end
    else if (bus_valid && bus_meas_en && bus_ch != 2'h3)
    begin
      above_upper[bus_ch] <= signed_gt(bus_volt, power_good_upper_limit);
      below_lower[bus_ch] <= signed_gt(power_good_lower_limit, bus_volt);
    end
  end

  // Power-good state doubles as the flag readback, so the two never disagree
  always @(posedge core_clk)
  begin
    if (rst_all)
      power_good_pin <= 1'b0;
    else if (!power_good_pin && (&above_upper))
      power_good_pin <= 1'b1;
    else if (power_good_pin && (|below_lower))
      power_good_pin <= 1'b0;
  end

  // Timing-control flag: high from reset, once dropped it stays down
  always @(posedge core_clk)
  begin
    if (rst_all)
      timing_ctrl_pin <= 1'b1;
    else if (timing_ctrl_event)
      timing_ctrl_pin <= 1'b0;
  end

endmodule // afpv_alert_bank

`default_nettype wire

// file: tb/afpv_checker.sv
// Port-level assertions for the alert and power-good register bank
`timescale 1ns/100ps
`default_nettype none
module afpv_checker
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       soft_reset,
  input wire logic [2:0] crit_over,
  input wire logic       sum_over,
  input wire logic [2:0] warn_over,
  input wire logic       bus_meas_en,
  input wire logic       bus_valid,
  input wire logic       timing_ctrl_event,
  input wire logic       critical_alert_n,
  input wire logic       warning_alert_n,
  input wire logic       power_good_pin,
  input wire logic       timing_ctrl_pin
);
  // Either reset puts the alert and power-good logic back to its start values, so checks pause
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst || soft_reset);

  // Alert pins follow their causes one cycle later
  property p_crit_pin; (|crit_over) |=> !critical_alert_n; endproperty
  a_crit_pin: assert property (p_crit_pin) else $error("critical pin missed channel");
  property p_sum_pin; sum_over |=> !critical_alert_n; endproperty
  a_sum_pin: assert property (p_sum_pin) else $error("critical pin missed sum");
  property p_warn_pin; (|warn_over) |=> !warning_alert_n; endproperty
  a_warn_pin: assert property (p_warn_pin) else $error("warning pin missed channel");
  // A pin never asserts without a cause the cycle before
  property p_crit_cause; $fell(critical_alert_n) |-> $past(|crit_over || sum_over); endproperty
  a_crit_cause: assert property (p_crit_cause) else $error("critical pin without cause");
  property p_warn_cause; $fell(warning_alert_n) |-> $past(|warn_over); endproperty
  a_warn_cause: assert property (p_warn_cause) else $error("warning pin without cause");
  // Timing-control drops on its event and only a reset restores it
  property p_tc_event; timing_ctrl_event |=> !timing_ctrl_pin; endproperty
  a_tc_event: assert property (p_tc_event) else $error("timing pin missed event");
  property p_tc_hold; $rose(timing_ctrl_pin) |-> $past(soft_reset) || !$past(nrst); endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("timing pin rose without reset");
  // Power-good moves only two cycles after an enabled bus reading, or falls after a reset
  property p_pg_rise; $rose(power_good_pin) |-> $past(bus_valid && bus_meas_en, 2); endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("power good rose without reading");
  property p_pg_fall;
    $fell(power_good_pin) |-> $past(bus_valid && bus_meas_en, 2) || $past(soft_reset)
                              || !$past(nrst);
  endproperty
  a_pg_fall: assert property (p_pg_fall) else $error("power good fell without reading");

  c_crit: cover property (!critical_alert_n);
  c_pg: cover property ($rose(power_good_pin));
  c_tc: cover property ($fell(timing_ctrl_pin));
endmodule // afpv_checker
`default_nettype wire

// file: tb/afpv_host_model.sv
// Two-wire bus host that reads and writes 16-bit registers of the bank
`timescale 1ns/100ps
`default_nettype none
`include "afpv_consts.vh"
module afpv_host_model
(
  input  wire logic core_clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_rel
);
  localparam int QTR = 6;

  // Idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Lines change only just after a core edge, a quarter bit apart
  task automatic qt();
    repeat (QTR) @(posedge core_clk);
    #1;
  endtask

  // Also serves as repeated START from mid-frame, where the clock is low
  task automatic start();
    sda_rel = 1'b1;
    qt();
    scl = 1'b1;
    qt();
    sda_rel = 1'b0;
    qt();
    scl = 1'b0;
    qt();
  endtask

  task automatic stop();
    sda_rel = 1'b0;
    qt();
    scl = 1'b1;
    qt();
    sda_rel = 1'b1;
    qt();
  endtask

  // Data is sampled mid-way through the high phase, well after the device settles
  task automatic clk_bit(input logic b, output logic s);
    sda_rel = b;
    qt();
    scl = 1'b1;
    qt();
    s = sda;
    qt();
    scl = 1'b0;
    qt();
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(mack, ack);
  endtask

  // Word write: MSB byte then LSB byte; ok reports the address acknowledge
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    xfer(d[15:8], 1'b1, rx, a1);
    xfer(d[7:0], 1'b1, rx, a1);
    stop();
    ok = !a0;
  endtask

  // Pointer write, repeated START, two bytes with NACK on the last
  task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({`AFPV_DEV_ADDR, 1'b0}, 1'b1, rx, a);
    xfer(ptr, 1'b1, rx, a);
    start();
    xfer({`AFPV_DEV_ADDR, 1'b1}, 1'b1, rx, a);
    xfer(8'hff, 1'b0, d[15:8], a);
    xfer(8'hff, 1'b1, d[7:0], a);
    stop();
  endtask
endmodule // afpv_host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the alert and power-good register bank
`timescale 1ns/100ps
`default_nettype none
`include "afpv_consts.vh"
module tb;
  typedef struct {logic [2:0] c; logic s; logic [2:0] w; logic v; logic [15:0] e;} afpv_row_t;
  logic        core_clk, nrst, soft_reset, cfg_write_clear, conv_done, sum_over;
  logic        bus_meas_en, bus_valid, timing_ctrl_event, ok;
  logic [2:0]  crit_over, warn_over, sel;
  logic [1:0]  bus_ch;
  logic [15:0] bus_volt, rv;
  logic        sda_out, sda_oe, crit_n, warn_n, pg, tc, scl, sda_rel;
  int          num_errors = 0;
  int          checks = 0;
  // Open-drain data line with pull-up
  wire         sda = sda_oe ? 1'b0 : sda_rel;
  // Causes held two cycles, then the mask word expected on the first read
  afpv_row_t rows [4] = '{'{3'b010, 1'b0, 3'b000, 1'b0, 16'h0102},
                          '{3'b000, 1'b1, 3'b000, 1'b0, 16'h0042},
                          '{3'b000, 1'b0, 3'b101, 1'b1, 16'h002b},
                          '{3'b101, 1'b1, 3'b111, 1'b0, 16'h02fa}};

  afpv_alert_bank dut_u (.core_clk(core_clk), .nrst(nrst), .scl_pin(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .soft_reset(soft_reset),
    .cfg_write_clear(cfg_write_clear), .conv_done(conv_done), .crit_over(crit_over),
    .sum_over(sum_over), .warn_over(warn_over), .bus_meas_en(bus_meas_en),
    .bus_valid(bus_valid), .bus_ch(bus_ch), .bus_volt(bus_volt),
    .timing_ctrl_event(timing_ctrl_event), .sum_channel_select(sel),
    .critical_alert_n(crit_n), .warning_alert_n(warn_n), .power_good_pin(pg),
    .timing_ctrl_pin(tc));
  afpv_host_model hm_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] ptr, input logic [15:0] exp);
    hm_u.rd(ptr, rv);
    cmp($sformatf("register %h", ptr), exp, rv);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One reading; a spare cycle keeps two pulses apart
  task automatic bv(input logic [1:0] ch, input logic [15:0] v);
    bus_ch = ch;
    bus_volt = v;
    bus_valid = 1'b1;
    cyc(1);
    bus_valid = 1'b0;
    cyc(1);
  endtask

  // Hang guard, well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  initial
  begin
    {nrst, soft_reset, cfg_write_clear, conv_done, sum_over, bus_valid} = 6'h00;
    {bus_meas_en, timing_ctrl_event, crit_over, warn_over, bus_ch, bus_volt} = 26'h0;
    cyc(12);
    nrst = 1'b1;
    cyc(3);
    rdchk(8'h0f, 16'h0002);
    rdchk(8'h10, 16'h2710);
    rdchk(8'h11, 16'h2328);
    rdchk(8'hfe, `AFPV_MAKER_CODE);
    rdchk(8'hff, `AFPV_DIE_CODE);
    cmp("timing pin", 16'h1, 16'(tc));
    foreach (rows[i])
    begin
      {crit_over, sum_over, warn_over, conv_done} = {rows[i].c, rows[i].s, rows[i].w, rows[i].v};
      cyc(1);
      conv_done = 1'b0;
      cyc(1);
      cmp("critical pin", 16'(!(|rows[i].c || rows[i].s)), 16'(crit_n));
      cmp("warning pin", 16'(!(|rows[i].w)), 16'(warn_n));
      {crit_over, sum_over, warn_over} = 7'h00;
      cyc(2);
      cmp("critical idle", 16'h1, 16'(crit_n));
      cmp("warning idle", 16'h1, 16'(warn_n));
      rdchk(8'h0f, rows[i].e);
      rdchk(8'h0f, 16'h0002);
    end
    // Flag bits ignore writes; reserved bit 15 stays zero
    hm_u.wr(`AFPV_DEV_ADDR, 8'h0f, 16'hffff, ok);
    rdchk(8'h0f, 16'h7c02);
    cmp("sum select", 16'h7, 16'(sel));
    hm_u.wr(`AFPV_DEV_ADDR, 8'h0f, 16'h4000, ok);
    cmp("sum select", 16'h4, 16'(sel));
    hm_u.rd(8'h0f, rv);
    hm_u.wr(`AFPV_DEV_ADDR, 8'h0f, 16'h0c00, ok);
    {crit_over, warn_over} = 6'b010010;
    cyc(1);
    {crit_over, warn_over} = 6'h00;
    cyc(3);
    cmp("critical latched", 16'h0, 16'(crit_n));
    cmp("warning latched", 16'h0, 16'(warn_n));
    rdchk(8'h0f, 16'h0d12);
    cmp("critical released", 16'h1, 16'(crit_n));
    cmp("warning released", 16'h1, 16'(warn_n));
    conv_done = 1'b1;
    cyc(1);
    conv_done = 1'b0;
    cfg_write_clear = 1'b1;
    cyc(1);
    cfg_write_clear = 1'b0;
    cyc(1);
    rdchk(8'h0f, 16'h0c02);
    // Readings equal to the upper limit do not count as above it
    bus_meas_en = 1'b1;
    for (int k = 0; k < 3; k++)
      bv(2'(k), 16'h2710);
    cyc(3);
    cmp("power good", 16'h0, 16'(pg));
    for (int k = 0; k < 3; k++)
      bv(2'(k), 16'h2718);
    cyc(2);
    cmp("power good", 16'h1, 16'(pg));
    rdchk(8'h0f, 16'h0c06);
    rdchk(8'h0f, 16'h0c06);
    bv(2'd1, 16'h2320);
    cyc(2);
    cmp("power good", 16'h0, 16'(pg));
    rdchk(8'h0f, 16'h0c02);
    timing_ctrl_event = 1'b1;
    cyc(1);
    timing_ctrl_event = 1'b0;
    cyc(2);
    cmp("timing pin", 16'h0, 16'(tc));
    rdchk(8'h0f, 16'h0c00);
    hm_u.wr(`AFPV_DEV_ADDR, 8'h10, 16'hffff, ok);
    rdchk(8'h10, 16'hfff8);
    hm_u.wr(`AFPV_DEV_ADDR, 8'hfe, 16'h1234, ok);
    rdchk(8'hfe, `AFPV_MAKER_CODE);
    hm_u.wr(`AFPV_DEV_ADDR ^ 7'h01, 8'h11, 16'h0000, ok);
    cmp("address acknowledge", 16'h0, 16'(ok));
    rdchk(8'h11, 16'h2328);
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    cyc(2);
    cmp("timing pin", 16'h1, 16'(tc));
    rdchk(8'h0f, 16'h0002);
    rdchk(8'h10, 16'h2710);
    close_out();
  end
endmodule // tb

bind afpv_alert_bank afpv_checker chk_u (.core_clk(core_clk), .nrst(nrst),
  .soft_reset(soft_reset), .crit_over(crit_over), .sum_over(sum_over),
  .warn_over(warn_over), .bus_meas_en(bus_meas_en), .bus_valid(bus_valid),
  .timing_ctrl_event(timing_ctrl_event), .critical_alert_n(critical_alert_n),
  .warning_alert_n(warning_alert_n), .power_good_pin(power_good_pin),
  .timing_ctrl_pin(timing_ctrl_pin));
`default_nettype wire
